// ---- pll_clock_pkg.sv ----
// How it works
// R01: four-bit multiplier field sets cpu clock rate
// R02: software disables watchdog before multiplier writes
// R03: lock needs 131072 oscillator cycles after write
// R04: software keeps pll output at most 300 MHz
// R05: bypass and multiplied ratios follow divider select
// R06: peripheral clock enables act two cycles later
// R07: system clock output equals cpu input clock
// R08: divider select zero before writes, change after lock
// R09: run bypassed until lock, then multiplied clock
// R10: only pin or watchdog reset restores pll registers
// R11: software writes bypass before powering pll down
// R12: lock flag sets after lock, clears on write
package pll_clock_pkg;
  localparam logic [15:0] OFS_PLL_STATE = 16'h7011;
  localparam logic [15:0] OFS_FAST_PERIPH_PRESCALE = 16'h701a;
  localparam logic [15:0] OFS_SLOW_PERIPH_PRESCALE = 16'h701b;
  localparam logic [15:0] OFS_PERIPH_CLOCK_GATE_A = 16'h701c;
  localparam logic [15:0] OFS_PERIPH_CLOCK_GATE_B = 16'h701d;
  localparam logic [15:0] OFS_SLEEP_MODE_CONTROL = 16'h701e;
  localparam logic [15:0] OFS_PERIPH_CLOCK_GATE_C = 16'h7020;
  localparam logic [15:0] OFS_PLL_MULTIPLIER_CONTROL = 16'h7021;
  localparam logic [15:0] OFS_SYSTEM_CONTROL_STATE = 16'h7022;
  localparam logic [15:0] OFS_TIMEOUT_COUNTER_VALUE = 16'h7023;
  localparam logic [15:0] OFS_TIMEOUT_SERVICE_KEY = 16'h7025;
  localparam logic [15:0] OFS_TIMEOUT_CONTROL = 16'h7029;
  localparam logic [15:0] OFS_PWM_REMAP_CONFIG = 16'h702e;

  localparam int MULT_LSB = 0;
  localparam int LOCK_BIT = 0;
  localparam int POWER_DOWN_BIT = 1;
  localparam int DIVIDER_SELECT_LSB = 7;
  localparam logic [3:0] MULT_BYPASS = 4'h0;
  localparam logic [3:0] MULT_MAX_CODE = 4'ha;
  localparam logic [3:0] MULT_UNITY = 4'h1;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic POWER_DOWN_RESET = 1'h0;

  localparam int LOCK_OSC_CYCLES = 131072;
  localparam int LOCK_COUNT_WIDTH = 18;
  localparam int PERIPH_GATE_DELAY = 2;

  typedef enum logic [1:0] {
    DIVIDER_SELECT_QUARTER_A = 2'b00,
    DIVIDER_SELECT_QUARTER_B = 2'b01,
    DIVIDER_SELECT_HALF = 2'b10,
    DIVIDER_SELECT_FULL = 2'b11
  } divider_select_type;

  typedef enum logic [1:0] {
    MODE_BYPASS = 2'b00,
    MODE_LOCKING = 2'b01,
    MODE_ENABLED = 2'b10,
    MODE_OFF = 2'b11
  } pll_mode_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic [3:0] mult;
    logic [1:0] shift;
  } clock_ratio_type;

  typedef struct packed {
    logic [LOCK_COUNT_WIDTH-1:0] count;
    logic locked;
  } timer_state_type;

  typedef struct packed {
    pll_mode_type mode;
    logic [3:0] mult;
    divider_select_type divider_select;
    logic power_down;
    logic [15:0] fast_pre;
    logic [15:0] slow_pre;
    logic [15:0] gate_a;
    logic [15:0] gate_b;
    logic [15:0] gate_c;
    logic [15:0] sleep_ctl;
    logic [15:0] sys_ctl;
    logic [15:0] key;
    logic [15:0] wd_ctl;
    logic [15:0] remap;
    logic [47:0] gate_out;
    clock_ratio_type ratio;
    logic [3:0] acc;
    logic [2:0] ticks;
    logic [15:0] rd_data;
  } top_state_type;

  // divide as a right shift: /4, /2 or /1
  function automatic logic [1:0] ratio_shift(input divider_select_type sel,
                                             input logic enabled);
    unique case (sel)
      DIVIDER_SELECT_QUARTER_A, DIVIDER_SELECT_QUARTER_B: ratio_shift = 2'h2;
      DIVIDER_SELECT_HALF: ratio_shift = 2'h1;
      // /1 is undefined with pll running; fall back to /2
      DIVIDER_SELECT_FULL: ratio_shift = enabled ? 2'h1 : 2'h0;
    endcase
  endfunction : ratio_shift

  function automatic logic valid_mult(input logic [3:0] code);
    valid_mult = code <= MULT_MAX_CODE;
  endfunction : valid_mult
endpackage : pll_clock_pkg

// ---- pll_lock_timer.sv ----
`timescale 1ns/100ps
module pll_lock_timer
  import pll_clock_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_OSC_CYCLES
) (
  input wire logic clk, // oscillator clock
  input wire logic rst_n, // synchronous reset
  input wire logic restart, // new multiplier, count again
  input wire logic hold, // pll powered down
  output logic locked // settling period done
);
  timer_state_type st;
  timer_state_type next_st;
  logic [LOCK_COUNT_WIDTH:0] since;

  always_comb begin
    next_st = st;
    if (!rst_n || restart || hold) begin
      next_st = '0;
    end else if (!st.locked) begin
      if (st.count == LOCK_COUNT_WIDTH'(LOCK_CYCLES - 1)) begin
        next_st.locked = 1'h1; // R03 R12
      end else begin
        next_st.count = st.count + 1'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign locked = st.locked;

  // cycles since the last restart, for checking only
  always_ff @(posedge clk) begin
    if (!rst_n || restart || hold) begin
      since <= '0;
    end else if (~&since) begin
      since <= since + 1'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_lock_period: assert property ($rose(locked) |-> since == (LOCK_CYCLES)) // R03
    else $error("lock flag rose before settling period ended");
  chk_lock_restart: assert property (restart |=> !locked) // R12
    else $error("lock flag survived a restart");
endmodule : pll_lock_timer

// ---- pll_clock_control.sv ----
`timescale 1ns/100ps
module pll_clock_control
  import pll_clock_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_OSC_CYCLES
) (
  input wire logic clk, // oscillator clock, 125 MHz
  input wire logic rst_n, // external reset pin, sync low
  input wire logic watchdog_reset, // watchdog reset pulse
  input wire logic debugger_reset, // debugger reset pulse
  input wire logic missing_clock_reset, // clock-loss reset pulse
  input wire bus_req_type bus, // register port request
  output logic [15:0] rd_data, // read data, cycle after strobe
  output clock_ratio_type cpu_ratio, // cpu clock multiplier and shift
  output logic [2:0] cpu_input_clock_ticks, // cpu edges this cycle
  output logic [2:0] system_clock_output_ticks, // same as cpu clock
  output pll_mode_type pll_mode, // bypass, locking, enabled, off
  output logic lock_flag, // pll settled
  output logic [15:0] periph_clock_enable_a, // gate a enables
  output logic [15:0] periph_clock_enable_b, // gate b enables
  output logic [15:0] periph_clock_enable_c // gate c enables
);
  top_state_type st;
  top_state_type next_st;
  logic pll_reset;
  logic sys_reset;
  logic mult_write;
  logic leave_off;
  logic timer_restart;
  logic locked;
  logic enabled;
  logic [4:0] sum;
  logic [4:0] mask;
  logic [15:0] read_value;

  pll_lock_timer #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) lock_timer (
    .clk(clk),
    .rst_n(rst_n),
    .restart(timer_restart),
    .hold(st.mode == MODE_OFF),
    .locked(locked)
  );

  always_comb begin
    next_st = st;
    // pll fields survive debugger and clock-loss resets
    pll_reset = !rst_n || watchdog_reset; // R10
    sys_reset = pll_reset || debugger_reset || missing_clock_reset;
    mult_write = bus.wr && bus.addr == OFS_PLL_MULTIPLIER_CONTROL
                 && valid_mult(bus.wdata[MULT_LSB +: 4]); // R05
    leave_off = 1'h0;
    read_value = REG_RESET;

    if (bus.wr) begin
      unique case (bus.addr)
        OFS_PLL_STATE: begin
          next_st.divider_select = divider_select_type'(bus.wdata[DIVIDER_SELECT_LSB +: 2]);
          next_st.power_down = bus.wdata[POWER_DOWN_BIT];
        end
        OFS_PLL_MULTIPLIER_CONTROL: begin
          // reserved codes are dropped so the pll never runs off-table
          if (mult_write) begin
            next_st.mult = bus.wdata[MULT_LSB +: 4]; // R01
          end
        end
        OFS_FAST_PERIPH_PRESCALE: next_st.fast_pre = bus.wdata;
        OFS_SLOW_PERIPH_PRESCALE: next_st.slow_pre = bus.wdata;
        OFS_PERIPH_CLOCK_GATE_A: next_st.gate_a = bus.wdata;
        OFS_PERIPH_CLOCK_GATE_B: next_st.gate_b = bus.wdata;
        OFS_PERIPH_CLOCK_GATE_C: next_st.gate_c = bus.wdata;
        OFS_SLEEP_MODE_CONTROL: next_st.sleep_ctl = bus.wdata;
        OFS_SYSTEM_CONTROL_STATE: next_st.sys_ctl = bus.wdata;
        OFS_TIMEOUT_SERVICE_KEY: next_st.key = bus.wdata;
        OFS_TIMEOUT_CONTROL: next_st.wd_ctl = bus.wdata;
        OFS_PWM_REMAP_CONFIG: next_st.remap = bus.wdata;
        default: ;
      endcase
    end

    unique case (st.mode)
      MODE_BYPASS, MODE_ENABLED: begin
        if (mult_write) begin
          // relock through bypass on any new nonzero multiplier; code 0 goes straight to bypass
          next_st.mode = (next_st.mult == MULT_BYPASS) ? MODE_BYPASS
                                                       : MODE_LOCKING; // R09
        end
      end
      MODE_LOCKING: begin
        if (mult_write && next_st.mult == MULT_BYPASS) begin
          next_st.mode = MODE_BYPASS;
        end else if (!mult_write && locked) begin
          next_st.mode = MODE_ENABLED; // R09
        end
      end
      MODE_OFF: begin
        if (!next_st.power_down) begin
          leave_off = 1'h1;
          next_st.mode = (next_st.mult == MULT_BYPASS) ? MODE_BYPASS : MODE_LOCKING;
        end
      end
    endcase
    if (next_st.power_down) begin
      next_st.mode = MODE_OFF;
    end

    timer_restart = mult_write || leave_off || watchdog_reset; // R12

    // fractional edge generator: cpu rate = osc * mult >> shift
    enabled = st.mode == MODE_ENABLED;
    next_st.ratio.mult = enabled ? st.mult : MULT_UNITY; // R05 R09
    next_st.ratio.shift = ratio_shift(st.divider_select, enabled); // R05
    sum = {1'h0, st.acc} + {1'h0, st.ratio.mult};
    mask = (5'h01 << st.ratio.shift) - 5'h01;
    next_st.ticks = 3'(sum >> st.ratio.shift);
    next_st.acc = 4'(sum & mask);

    // one extra stage so a gate write acts two cycles on
    next_st.gate_out = {st.gate_c, st.gate_b, st.gate_a}; // R06

    if (bus.rd) begin
      unique case (bus.addr)
        OFS_PLL_STATE: begin
          read_value[DIVIDER_SELECT_LSB +: 2] = st.divider_select;
          read_value[POWER_DOWN_BIT] = st.power_down;
          read_value[LOCK_BIT] = locked; // R12
        end
        OFS_PLL_MULTIPLIER_CONTROL: read_value[MULT_LSB +: 4] = st.mult;
        OFS_FAST_PERIPH_PRESCALE: read_value = st.fast_pre;
        OFS_SLOW_PERIPH_PRESCALE: read_value = st.slow_pre;
        OFS_PERIPH_CLOCK_GATE_A: read_value = st.gate_a;
        OFS_PERIPH_CLOCK_GATE_B: read_value = st.gate_b;
        OFS_PERIPH_CLOCK_GATE_C: read_value = st.gate_c;
        OFS_SLEEP_MODE_CONTROL: read_value = st.sleep_ctl;
        OFS_SYSTEM_CONTROL_STATE: read_value = st.sys_ctl;
        OFS_TIMEOUT_SERVICE_KEY: read_value = st.key;
        OFS_TIMEOUT_CONTROL: read_value = st.wd_ctl;
        OFS_PWM_REMAP_CONFIG: read_value = st.remap;
        // counter lives in the watchdog, not here
        OFS_TIMEOUT_COUNTER_VALUE: read_value = REG_RESET;
        default: read_value = REG_RESET;
      endcase
    end
    next_st.rd_data = read_value;

    if (sys_reset) begin
      next_st.fast_pre = REG_RESET;
      next_st.slow_pre = REG_RESET;
      next_st.gate_a = REG_RESET;
      next_st.gate_b = REG_RESET;
      next_st.gate_c = REG_RESET;
      next_st.sleep_ctl = REG_RESET;
      next_st.sys_ctl = REG_RESET;
      next_st.key = REG_RESET;
      next_st.wd_ctl = REG_RESET;
      next_st.remap = REG_RESET;
      next_st.gate_out = '0;
      next_st.rd_data = REG_RESET;
    end
    if (pll_reset) begin
      next_st.mode = MODE_BYPASS; // R10
      next_st.mult = MULT_BYPASS;
      next_st.divider_select = DIVIDER_SELECT_QUARTER_A;
      next_st.power_down = POWER_DOWN_RESET;
    end
    if (!rst_n) begin
      next_st.ratio = '{mult: MULT_UNITY, shift: 2'h2};
      next_st.acc = '0;
      next_st.ticks = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign rd_data = st.rd_data;
  assign cpu_ratio = st.ratio;
  assign cpu_input_clock_ticks = st.ticks;
  assign system_clock_output_ticks = st.ticks; // R07
  assign pll_mode = st.mode;
  assign lock_flag = locked;
  assign periph_clock_enable_a = st.gate_out[15:0];
  assign periph_clock_enable_b = st.gate_out[31:16];
  assign periph_clock_enable_c = st.gate_out[47:32];

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence good_mult_write;
    bus.wr && bus.addr == OFS_PLL_MULTIPLIER_CONTROL
    && valid_mult(bus.wdata[MULT_LSB +: 4]) && !watchdog_reset;
  endsequence

  sequence gate_a_write_alone;
    bus.wr && bus.addr == OFS_PERIPH_CLOCK_GATE_A && !sys_reset
    ##1 !(bus.wr && bus.addr == OFS_PERIPH_CLOCK_GATE_A) && !sys_reset;
  endsequence

  chk_mult_field_store: assert property ( // R01
    good_mult_write |=> st.mult == $past(bus.wdata[MULT_LSB +: 4]))
    else $error("multiplier field did not take the written code");

  chk_bypass_ratio: assert property ( // R05
    $past(st.mode) != MODE_ENABLED && !$past(!rst_n)
    |-> cpu_ratio.mult == MULT_UNITY
        && cpu_ratio.shift == ratio_shift($past(st.divider_select), 1'h0))
    else $error("bypass ratio does not follow divider select");

  chk_enabled_ratio: assert property ( // R05
    $past(st.mode) == MODE_ENABLED && !$past(!rst_n)
    |-> cpu_ratio.mult == $past(st.mult) && cpu_ratio.shift != 2'h0)
    else $error("enabled ratio does not use the multiplier");

  chk_gate_delay: assert property ( // R06
    gate_a_write_alone |=> periph_clock_enable_a == $past(bus.wdata, 2))
    else $error("peripheral enable not applied two cycles after write");

  // back-to-back gate writes legally move the enables one cycle on
  chk_gate_not_early: assert property ( // R06
    bus.wr && bus.addr == OFS_PERIPH_CLOCK_GATE_A && !sys_reset
    && !$past(bus.wr && bus.addr == OFS_PERIPH_CLOCK_GATE_A)
    |=> $stable(periph_clock_enable_a))
    else $error("peripheral enable applied too early");

  chk_sysclk_same: assert property ( // R07
    system_clock_output_ticks == cpu_input_clock_ticks)
    else $error("system clock output differs from cpu clock");

  chk_locking_bypass: assert property ( // R09
    good_mult_write ##0 bus.wdata[MULT_LSB +: 4] != MULT_BYPASS && !st.power_down
    && !(bus.wr && bus.addr == OFS_PLL_STATE)
    |=> pll_mode == MODE_LOCKING && !lock_flag)
    else $error("new multiplier did not start in bypass");

  chk_enabled_locked: assert property ( // R09
    pll_mode == MODE_ENABLED |-> lock_flag)
    else $error("multiplied clock used without lock");

  chk_pll_keep: assert property ( // R10
    (debugger_reset || missing_clock_reset) && !watchdog_reset && !bus.wr
    |=> $stable(st.mult) && $stable(st.divider_select) && $stable(st.power_down))
    else $error("soft reset disturbed pll registers");

  chk_pll_default: assert property ( // R10
    watchdog_reset |=> st.mult == MULT_BYPASS && st.divider_select == DIVIDER_SELECT_QUARTER_A
                       && pll_mode == MODE_BYPASS && !lock_flag)
    else $error("watchdog reset did not restore pll defaults");

  chk_lock_clear: assert property ( // R12
    good_mult_write |=> !lock_flag [*2])
    else $error("lock flag not cleared by multiplier write");
endmodule : pll_clock_control

// ---- osc_source.sv ----
`timescale 1ns/100ps
module osc_source (
  input wire logic clk, // oscillator clock seen by the block
  input wire logic rst_n, // external reset pin
  output logic [31:0] osc_count // oscillator cycles since reset
);
  // crystal runs free, so it never stalls between accesses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_count <= 32'h0000_0000;
    end else begin
      osc_count <= osc_count + 32'h0000_0001;
    end
  end
endmodule : osc_source

// ---- pll_clock_control_tb_top.sv ----
`timescale 1ns/100ps
module pll_clock_control_tb_top;
  import pll_clock_pkg::*;
  localparam int LOCK_N = 16;
  logic clk;
  logic rst_n;
  logic watchdog_reset;
  logic debugger_reset;
  logic missing_clock_reset;
  bus_req_type bus;
  logic [15:0] rd_data;
  clock_ratio_type cpu_ratio;
  logic [2:0] cpu_ticks;
  logic [2:0] sys_ticks;
  pll_mode_type pll_mode;
  logic lock_flag;
  logic [15:0] en_a;
  logic [15:0] en_b;
  logic [15:0] en_c;
  logic [31:0] osc_count;
  int mismatches;
  int checks;
  logic [15:0] rw_addr [8] = '{16'h701a, 16'h701b, 16'h701c, 16'h701d,
                               16'h701e, 16'h7020, 16'h7025, 16'h702e};

  pll_clock_control #(.LOCK_CYCLES(LOCK_N)) dut (.clk(clk), .rst_n(rst_n),
    .watchdog_reset(watchdog_reset), .debugger_reset(debugger_reset),
    .missing_clock_reset(missing_clock_reset), .bus(bus), .rd_data(rd_data),
    .cpu_ratio(cpu_ratio), .cpu_input_clock_ticks(cpu_ticks),
    .system_clock_output_ticks(sys_ticks), .pll_mode(pll_mode),
    .lock_flag(lock_flag), .periph_clock_enable_a(en_a),
    .periph_clock_enable_b(en_b), .periph_clock_enable_c(en_c));
  osc_source osc (.clk(clk), .rst_n(rst_n), .osc_count(osc_count));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rchk

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) watchdog_reset <= 1'b1;
    if (which == 1) debugger_reset <= 1'b1;
    if (which == 2) missing_clock_reset <= 1'b1;
    @(posedge clk);
    watchdog_reset <= 1'b0;
    debugger_reset <= 1'b0;
    missing_clock_reset <= 1'b0;
  endtask : pulse

  task automatic t_reset;
    #1;
    chk(pll_mode, MODE_BYPASS);
    chk(cpu_ratio, {4'h1, 2'h2});
    chk(lock_flag, 1'b0);
    chk({en_a, en_b, en_c}, 48'h0000_0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    for (int i = 0; i < 8; i++) wr(rw_addr[i], 16'h5a00 + 16'(i));
    for (int i = 0; i < 8; i++) rchk(rw_addr[i], 16'h5a00 + 16'(i));
    rchk(16'h7011, 16'h0001);
    @(posedge clk);
    #1;
    chk(rd_data, 16'h0000);
    rchk(16'h7012, 16'h0000);
    rchk(16'h701f, 16'h0000);
    wr(16'h7023, 16'hffff);
    rchk(16'h7023, 16'h0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_gate;
    wr(16'h701d, 16'h1234);
    #1;
    chk(en_b, 16'h5a03);
    @(posedge clk);
    #1;
    chk(en_b, 16'h1234);
    wr(16'h7020, 16'hc3c3);
    @(posedge clk);
    #1;
    chk(en_c, 16'hc3c3);
    $display("test gate done");
  endtask : t_gate

  task automatic t_pll;
    int n;
    int tick_sum;
    logic [31:0] osc_start;
    // park the watchdog before the clock moves
    wr(16'h7029, 16'h0040);
    rchk(16'h7029, 16'h0040);
    wr(16'h7011, 16'h0000);
    // 125 MHz times 2 keeps the pll output under its ceiling
    wr(16'h7021, 16'h0002);
    #1;
    osc_start = osc_count;
    chk(pll_mode, MODE_LOCKING);
    chk(lock_flag, 1'b0);
    chk(cpu_ratio, {4'h1, 2'h2});
    n = 0;
    while (lock_flag !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, LOCK_N);
    chk(osc_count - osc_start, LOCK_N);
    repeat (2) @(posedge clk);
    #1;
    chk(pll_mode, MODE_ENABLED);
    chk(cpu_ratio, {4'h2, 2'h2});
    rchk(16'h7011, 16'h0001);
    rchk(16'h7021, 16'h0002);
    tick_sum = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      tick_sum += cpu_ticks;
      chk(sys_ticks, cpu_ticks);
    end
    // eight cycles at 2/4 of the oscillator give four cpu edges
    chk(tick_sum, 4);
    wr(16'h7011, 16'h0100);
    repeat (3) @(posedge clk);
    #1;
    chk(cpu_ratio, {4'h2, 2'h1});
    wr(16'h7011, 16'h0000);
    wr(16'h7021, 16'h000b);
    #1;
    chk(pll_mode, MODE_ENABLED);
    rchk(16'h7021, 16'h0002);
    $display("test pll done");
  endtask : t_pll

  task automatic t_resets;
    pulse(1);
    pulse(2);
    rchk(16'h7021, 16'h0002);
    rchk(16'h701a, 16'h0000);
    pulse(0);
    rchk(16'h7021, 16'h0000);
    rchk(16'h7011, 16'h0000);
    $display("test resets done");
  endtask : t_resets

  task automatic t_power;
    wr(16'h7021, 16'h0000);
    // divider may only move once the relock has settled
    repeat (LOCK_N) @(posedge clk);
    #1;
    chk(lock_flag, 1'b1);
    wr(16'h7011, 16'h0182);
    repeat (3) @(posedge clk);
    #1;
    chk(pll_mode, MODE_OFF);
    chk(lock_flag, 1'b0);
    chk(cpu_ratio.shift, 2'h0);
    $display("test power down done");
  endtask : t_power

  initial begin
    rst_n = 1'b0;
    watchdog_reset = 1'b0;
    debugger_reset = 1'b0;
    missing_clock_reset = 1'b0;
    bus = '0;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_gate();
    t_pll();
    t_resets();
    t_power();
    end_sim();
  end

  // whole run is under 200 cycles; this leaves wide margin
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : pll_clock_control_tb_top
